// [ccc_pkg.sv]
// package: constants and types for the converter calibration control block
package ccc_pkg;
    // ========================================================================
    // register map
    localparam logic [3:0]  ADDR_CONFIG      = 4'h0;
    localparam logic [3:0]  ADDR_CAL_ADJUST  = 4'h4;
    localparam logic [3:0]  ADDR_CAL_STATUS  = 4'hE;
    localparam int          CFG_CAL_REQ_BIT  = 15;
    localparam int          ADJ_SEQ_BIT      = 14;
    localparam int          ADJ_MODE_LSB     = 12;
    localparam logic [15:0] CONFIG_RESET     = 16'h0000;
    localparam logic [15:0] CAL_ADJUST_RESET = 16'h4000;
    localparam logic [15:0] CAL_ADJUST_MASK  = 16'h7000;
    localparam logic [1:0]  MODE_ILLEGAL     = 2'h3;
    // ========================================================================
    // timing, in sampling clock cycles
    localparam int          CAL_LOW_CYCLES   = 80;
    localparam int          CAL_HIGH_CYCLES  = 80;
    localparam int          WAIT_SHORT_CYC   = 1024;
    localparam int          WAIT_LONG_CYC    = 16384;
    localparam int          CAL_BASE_CYC     = 2000;
    localparam int          FLUSH_CYCLES     = 60;
    // ========================================================================
    // sequencer states
    typedef enum logic [2:0] {
        CCC_POR_WAIT,
        CCC_IDLE,
        CCC_RUN,
        CCC_HALT,
        CCC_FLUSH
    } ccc_state_t;
endpackage : ccc_pkg

// [ccc_qualifier.sv]
// module: low-then-high request qualifier
`timescale 1ns/1ps
module ccc_qualifier #(
    parameter int LOW_CYC  = ccc_pkg::CAL_LOW_CYCLES,
    parameter int HIGH_CYC = ccc_pkg::CAL_HIGH_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // request level, already synchronous
    input  wire logic req,
    // one-cycle qualified request
    output logic      fire
);
    logic [15:0] cnt_reg, cnt_next;
    logic        low_ok_reg, low_ok_next;
    logic        prev_reg, prev_next;
    logic        fire_next;

    // ========================================================================
    // counter restarts on any level change; high phase counts only after low
    always_comb begin
        cnt_next    = cnt_reg;
        low_ok_next = low_ok_reg;
        prev_next   = req;
        fire_next   = 1'b0;
        if (req != prev_reg) begin
            cnt_next = 16'h0001;
            if (req && cnt_reg < 16'(LOW_CYC)) begin
                low_ok_next = 1'b0;
            end
        end else if (cnt_reg != 16'hFFFF) begin
            cnt_next = cnt_reg + 16'h0001;
        end
        if (!req && cnt_reg >= 16'(LOW_CYC - 1)) begin
            low_ok_next = 1'b1;
        end
        if (req && low_ok_reg && prev_reg && cnt_reg == 16'(HIGH_CYC - 1)) begin
            fire_next   = 1'b1;
            low_ok_next = 1'b0;
        end
    end

    // registers; start as if the line has been high, so no stale low counts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg    <= 16'h0000;
            low_ok_reg <= 1'b0;
            prev_reg   <= 1'b1;
            fire       <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            low_ok_reg <= low_ok_next;
            prev_reg   <= prev_next;
            fire       <= fire_next;
        end
    end

    a_fire_after_high: assert property (@(posedge clk) disable iff (!rst_n)
        fire |-> $past(req) && $past(req, 2))
        else $error("request fired without high level");
endmodule : ccc_qualifier

// [ccc_top.sv]
// module: calibration sequencing, status output and output blanking
`timescale 1ns/1ps
module ccc_top #(
    parameter int WAIT_SHORT = ccc_pkg::WAIT_SHORT_CYC,
    parameter int WAIT_LONG  = ccc_pkg::WAIT_LONG_CYC,
    parameter int CAL_BASE   = ccc_pkg::CAL_BASE_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // pins
    input  wire logic        cal_request_pin,
    input  wire logic        power_on_delay_select,
    input  wire logic        extended_control_mode,
    input  wire logic        power_down_i_channel,
    input  wire logic        power_down_q_channel,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // status and output control
    output logic             calibration_active,
    output logic             data_valid,
    output logic             output_blank,
    output logic             output_data_clock,
    output logic [1:0]       cal_sequence_mode,
    output logic             cal_full_sequence
);
    logic [1:0]  req_sync, dly_sync, pdi_sync, pdq_sync, ecm_sync;
    logic        req_any, qual_fire, both_down;
    logic        dly_prev_reg;
    logic        skip_reg, skip_next;
    logic [15:0] cfg_reg, cfg_next, adj_reg, adj_next, rdata_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] cal_len;
    ccc_pkg::ccc_state_t state_reg, state_next;
    logic        active_next, valid_next, clk_next;

    // ========================================================================
    // two-flop synchronisers for every pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_sync <= 2'h0;
            dly_sync <= 2'h0;
            pdi_sync <= 2'h0;
            pdq_sync <= 2'h0;
            ecm_sync <= 2'h0;
        end else begin
            req_sync <= {req_sync[0], cal_request_pin};
            dly_sync <= {dly_sync[0], power_on_delay_select};
            pdi_sync <= {pdi_sync[0], power_down_i_channel};
            pdq_sync <= {pdq_sync[0], power_down_q_channel};
            ecm_sync <= {ecm_sync[0], extended_control_mode};
        end
    end

    // bit only counts in extended mode
    assign req_any   = req_sync[1] | (ecm_sync[1] & cfg_reg[ccc_pkg::CFG_CAL_REQ_BIT]);
    assign both_down = pdi_sync[1] & pdq_sync[1];

    ccc_qualifier u_qual (
        .clk   (clk),
        .rst_n (rst_n),
        .req   (req_any),
        .fire  (qual_fire)
    );

    // calibration length from mode; illegal mode treated as the default
    always_comb begin
        unique case (adj_reg[ccc_pkg::ADJ_MODE_LSB +: 2])
            2'h1:    cal_len = 16'(CAL_BASE / 2);
            2'h2:    cal_len = 16'(CAL_BASE / 4);
            default: cal_len = 16'(CAL_BASE);
        endcase
    end

    // ========================================================================
    // register file; accesses during calibration still land, user must avoid
    always_comb begin
        cfg_next   = cfg_reg;
        adj_next   = adj_reg;
        rdata_next = 16'h0000;
        if (reg_write && reg_addr == ccc_pkg::ADDR_CONFIG) begin
            cfg_next = reg_wdata;
        end
        if (reg_write && reg_addr == ccc_pkg::ADDR_CAL_ADJUST) begin
            adj_next = reg_wdata & ccc_pkg::CAL_ADJUST_MASK;
            if (reg_wdata[ccc_pkg::ADJ_MODE_LSB +: 2] == ccc_pkg::MODE_ILLEGAL) begin
                adj_next[ccc_pkg::ADJ_MODE_LSB +: 2] = adj_reg[ccc_pkg::ADJ_MODE_LSB +: 2];
            end
        end
        if (reg_read) begin
            unique case (reg_addr)
                ccc_pkg::ADDR_CONFIG:     rdata_next = cfg_reg;
                ccc_pkg::ADDR_CAL_ADJUST: rdata_next = adj_reg;
                ccc_pkg::ADDR_CAL_STATUS: rdata_next = {13'h0000, skip_reg,
                                                        data_valid, calibration_active};
                default:                  rdata_next = 16'h0000;
            endcase
        end
    end

    // ========================================================================
    // sequencer: one run state serves every trigger
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        skip_next   = skip_reg;
        unique case (state_reg)
            ccc_pkg::CCC_POR_WAIT: begin
                cnt_next = cnt_reg + 16'h0001;
                if (req_sync[1]) begin
                    skip_next  = 1'b1;
                    state_next = ccc_pkg::CCC_IDLE;
                    cnt_next   = 16'h0000;
                end else if (cnt_reg >= 16'(dly_sync[1] ? WAIT_LONG - 1 : WAIT_SHORT - 1)) begin
                    state_next = ccc_pkg::CCC_RUN;
                    cnt_next   = 16'h0000;
                end
            end
            ccc_pkg::CCC_IDLE: begin
                if (qual_fire) begin
                    state_next = ccc_pkg::CCC_RUN;
                    skip_next  = 1'b0;
                    cnt_next   = 16'h0000;
                end else if (dly_sync[1] != dly_prev_reg && !req_any) begin
                    state_next = ccc_pkg::CCC_RUN;
                    skip_next  = 1'b0; // a finished run makes data valid again
                    cnt_next   = 16'h0000;
                end
            end
            ccc_pkg::CCC_RUN: begin
                cnt_next    = cnt_reg + 16'h0001;
                if (both_down) begin
                    state_next = ccc_pkg::CCC_HALT;
                    cnt_next   = cnt_reg;
                end else if (cnt_reg >= cal_len - 16'h0001) begin
                    state_next  = ccc_pkg::CCC_FLUSH;
                    cnt_next    = 16'h0000;
                end
            end
            ccc_pkg::CCC_HALT: begin
                if (!both_down) begin
                    state_next = ccc_pkg::CCC_RUN;
                end
            end
            ccc_pkg::CCC_FLUSH: begin
                cnt_next = cnt_reg + 16'h0001;
                if (cnt_reg >= 16'(ccc_pkg::FLUSH_CYCLES - 1)) begin
                    state_next = ccc_pkg::CCC_IDLE;
                    cnt_next   = 16'h0000;
                end
            end
        endcase
        // status and valid follow the next state, so no run cycle shows idle
        active_next = state_next == ccc_pkg::CCC_RUN
                   || state_next == ccc_pkg::CCC_HALT;
        valid_next  = state_next == ccc_pkg::CCC_IDLE && !skip_next;
    end

    // data clock toggles in every state so capture logic keeps its lock
    assign clk_next = !output_data_clock;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg          <= ccc_pkg::CCC_POR_WAIT;
            cnt_reg            <= 16'h0000;
            skip_reg           <= 1'b0;
            dly_prev_reg       <= 1'b0;
            cfg_reg            <= ccc_pkg::CONFIG_RESET;
            adj_reg            <= ccc_pkg::CAL_ADJUST_RESET;
            reg_rdata          <= 16'h0000;
            calibration_active <= 1'b0;
            data_valid         <= 1'b0;
            output_blank       <= 1'b1;
            output_data_clock  <= 1'b0;
            cal_sequence_mode  <= 2'h0;
            cal_full_sequence  <= 1'b1;
        end else begin
            state_reg          <= state_next;
            cnt_reg            <= cnt_next;
            skip_reg           <= skip_next;
            dly_prev_reg       <= dly_sync[1];
            cfg_reg            <= cfg_next;
            adj_reg            <= adj_next;
            reg_rdata          <= rdata_next;
            calibration_active <= active_next;
            data_valid         <= valid_next;
            output_blank       <= !valid_next;
            output_data_clock  <= clk_next;
            cal_sequence_mode  <= adj_reg[ccc_pkg::ADJ_MODE_LSB +: 2];
            cal_full_sequence  <= adj_reg[ccc_pkg::ADJ_SEQ_BIT];
        end
    end

    // ========================================================================
    a_active_blank: assert property (@(posedge clk) disable iff (!rst_n)
        calibration_active |-> output_blank)
        else $error("outputs not blanked during calibration");
    a_output_data_clock_toggles: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> output_data_clock != $past(output_data_clock))
        else $error("data clock stopped");
    a_flush_gap: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(calibration_active) |-> !data_valid [*8])
        else $error("data valid too soon after calibration");
    a_halt_holds: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == ccc_pkg::CCC_HALT |-> calibration_active)
        else $error("status dropped while halted");
    a_run_status: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == ccc_pkg::CCC_RUN && $past(state_reg) == ccc_pkg::CCC_RUN
        |-> calibration_active)
        else $error("status low while running");
    a_skip_idle: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(skip_reg) |-> state_reg == ccc_pkg::CCC_IDLE)
        else $error("skip did not go idle");
    a_fire_starts: assert property (@(posedge clk) disable iff (!rst_n)
        qual_fire && state_reg == ccc_pkg::CCC_IDLE |=> state_reg == ccc_pkg::CCC_RUN)
        else $error("qualified request ignored");
    a_mode_legal: assert property (@(posedge clk) disable iff (!rst_n)
        adj_reg[ccc_pkg::ADJ_MODE_LSB +: 2] != ccc_pkg::MODE_ILLEGAL)
        else $error("illegal calibration mode stored");
endmodule : ccc_top

// [ccc_ctrl_model.sv]
// file: system controller model that drives the calibration control pins
`timescale 1ns/1ps
module ccc_ctrl_model (
    // clock
    input  wire logic clk,
    // pins toward the converter
    output logic      cal_request_pin,
    output logic      power_on_delay_select
);
    // ========================================================================
    // strap is fixed before power is applied, request idles low
    initial begin
        cal_request_pin       = 1'b0;
        power_on_delay_select = 1'b0;
    end
    // ========================================================================
    // low phase then high phase; the level stays high afterwards, so the
    // next call always lowers it first; only the request pin is driven
    task automatic request(input int lo, input int hi);
        repeat (lo) @(posedge clk) cal_request_pin <= 1'b0;
        repeat (hi) @(posedge clk) cal_request_pin <= 1'b1;
    endtask : request
    // plain level on the request pin, high keeps strap toggles harmless
    task automatic hold(input logic lvl);
        @(posedge clk) cal_request_pin <= lvl;
    endtask : hold
    // strap level
    task automatic strap(input logic lvl);
        @(posedge clk) power_on_delay_select <= lvl;
    endtask : strap
endmodule : ccc_ctrl_model

// [ccc_tb_top.sv]
// file: self-checking testbench for the calibration control block
`timescale 1ns/1ps
module ccc_tb_top;
    // ========================================================================
    // shortened counts so the run stays brief
    localparam int WS = 16;
    localparam int WL = 32;
    localparam int CB = 40;
    logic        clk       = 1'b0;
    logic        rst_n     = 1'b0;
    logic        ext_mode  = 1'b0;
    logic        pd_i      = 1'b0;
    logic        pd_q      = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic [15:0] reg_rdata;
    logic        req_pin;
    logic        strap;
    logic        active;
    logic        valid;
    logic        blank;
    logic        data_clk;
    logic        full_seq;
    logic [1:0]  mode;
    int          bad_count = 0;
    int          cmp_count = 0;
    // clock
    always #50 clk = ~clk;
    // ========================================================================
    // design and far-side model
    ccc_ctrl_model u_ctrl (.clk(clk), .cal_request_pin(req_pin), .power_on_delay_select(strap));
    ccc_top #(.WAIT_SHORT(WS), .WAIT_LONG(WL), .CAL_BASE(CB)) DUT (
        .clk(clk), .rst_n(rst_n), .cal_request_pin(req_pin), .power_on_delay_select(strap),
        .extended_control_mode(ext_mode), .power_down_i_channel(pd_i),
        .power_down_q_channel(pd_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .calibration_active(active), .data_valid(valid), .output_blank(blank),
        .output_data_clock(data_clk), .cal_sequence_mode(mode), .cal_full_sequence(full_seq));
    // ========================================================================
    // compare, verdict and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rst_cycle;
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
    endtask : rst_cycle
    // counts cycles in which a calibration shows when none may start
    task automatic quiet(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge clk);
            #1 if (active !== 1'b0) n++;
        end
    endtask : quiet
    // bounded wait for a start, then times the busy phase and the flush
    task automatic run_cal(input int lim, output int n);
        int   k;
        logic p;
        n = 0;
        k = 0;
        // step past the calling edge so outputs launched on it have settled
        #1;
        while (active !== 1'b1) begin
            @(posedge clk);
            #1 k++;
            if (k > lim) begin
                check(32'h0, 32'h1);
                summarize();
            end
        end
        while (active === 1'b1 && n < 1000) begin
            p = data_clk;
            @(posedge clk);
            #1 n++;
            check({blank, data_clk}, {1'b1, ~p});
        end
        k = 0;
        while (valid !== 1'b1 && k < 200) begin
            @(posedge clk);
            #1 k++;
        end
        check(k, ccc_pkg::FLUSH_CYCLES);
    endtask : run_cal
    // ========================================================================
    // main sequence
    initial begin
        logic [15:0] d;
        int          n;
        int          len;
        rst_cycle();
        quiet(WS - 4, n);
        check(n, 0);
        run_cal(10, len);
        check(len, CB);
        rd(ccc_pkg::ADDR_CAL_STATUS, d);
        check(d, 16'h0002);
        rd(ccc_pkg::ADDR_CAL_ADJUST, d);
        check(d, ccc_pkg::CAL_ADJUST_RESET);
        check({mode, full_seq}, 3'b001);
        rd(4'h7, d);
        check(d, 16'h0000);
        u_ctrl.request(84, 84);
        run_cal(10, len);
        check(len, CB);
        // too short high, then too short low: neither may qualify
        u_ctrl.request(84, 40);
        u_ctrl.request(30, 84);
        u_ctrl.hold(1'b0);
        quiet(150, n);
        check(n, 0);
        // register bit is ignored outside extended mode, ORed inside it
        wr(ccc_pkg::ADDR_CONFIG, 16'h8000);
        quiet(120, n);
        check(n, 0);
        wr(ccc_pkg::ADDR_CONFIG, 16'h0000);
        ext_mode <= 1'b1;
        quiet(90, n);
        check(n, 0);
        wr(ccc_pkg::ADDR_CONFIG, 16'h8000);
        run_cal(100, len);
        check(len, CB);
        wr(ccc_pkg::ADDR_CONFIG, 16'h0000);
        u_ctrl.strap(1'b1);
        run_cal(20, len);
        check(len, CB);
        // both channels down for 30 cycles in mid-run freeze the count
        u_ctrl.request(84, 84);
        fork
            run_cal(10, len);
            begin
                repeat (12) @(posedge clk);
                pd_i <= 1'b1;
                pd_q <= 1'b1;
                repeat (30) @(posedge clk);
                pd_i <= 1'b0;
                pd_q <= 1'b0;
            end
        join
        // 30 halted cycles plus the run cycle that sees both channels down
        check(len, CB + 31);
        for (int m = 0; m < 3; m++) begin
            wr(ccc_pkg::ADDR_CAL_ADJUST, {2'b00, 2'(m), 12'h000});
            @(posedge clk);
            #1 check({mode, full_seq}, {2'(m), 1'b0});
            u_ctrl.request(84, 84);
            run_cal(10, len);
            check(len, CB >> m);
        end
        wr(ccc_pkg::ADDR_CAL_ADJUST, 16'h3000);
        rd(ccc_pkg::ADDR_CAL_ADJUST, d);
        check(d, 16'h2000);
        wr(ccc_pkg::ADDR_CAL_ADJUST, ccc_pkg::CAL_ADJUST_RESET);
        // strap high selects the long wait
        u_ctrl.hold(1'b0);
        rst_cycle();
        quiet(WL - 4, n);
        check(n, 0);
        run_cal(10, len);
        check(len, CB);
        // request high at power-on skips, strap toggles stay harmless
        u_ctrl.hold(1'b1);
        rst_cycle();
        u_ctrl.strap(1'b0);
        quiet(WL + 40, n);
        check(n, 0);
        rd(ccc_pkg::ADDR_CAL_STATUS, d);
        check(d[2], 1'b1);
        u_ctrl.request(84, 84);
        run_cal(10, len);
        check(len, CB);
        summarize();
    end
endmodule : ccc_tb_top
